//--- core/rtcsp_defs.svh
// Constants for the three-wire command port: header layout, command codes, sizes.
// Assumes inclusion by bare name from the port's design files.
`ifndef RTCSP_DEFS_SVH
`define RTCSP_DEFS_SVH
`define RTCSP_PREAMBLE 4'h6
`define RTCSP_HDR_BITS 4'h8
`define RTCSP_CMD_RESET 3'h0
`define RTCSP_CMD_STATUS 3'h1
`define RTCSP_CMD_TIME_YEAR 3'h2
`define RTCSP_CMD_TIME_HOUR 3'h3
`define RTCSP_CMD_ALARM 3'h4
`define RTCSP_CMD_TEST_ON 3'h6
`define RTCSP_CMD_TEST_OFF 3'h7
`define RTCSP_STATUS_BITS 7'h08
`define RTCSP_TIME_BITS 7'h38
`define RTCSP_HOUR_BITS 7'h18
`define RTCSP_ALARM_BITS 7'h10
`define RTCSP_HOUR_OFFSET 7'h20
`define RTCSP_POWER_BIT 3'h7
`define RTCSP_TIME_RESET 56'h00000000010100
`define RTCSP_STATUS_RESET 8'h82
`define RTCSP_ALARM_RESET 16'h8000
`endif

//--- core/rtcsp_pkg.sv
// Types for the three-wire command port.
// Assumes rtcsp_defs.svh is available for constants.
package rtcsp_pkg;
   typedef enum logic [1:0] {PH_HEADER, PH_READ, PH_WRITE, PH_DONE} rtcsp_phase_t;
   typedef enum logic [2:0] {SEL_NONE, SEL_STATUS, SEL_TIME, SEL_HOUR, SEL_ALARM}
      rtcsp_sel_t;
endpackage

//--- core/rtcsp_pins_if.sv
// Bundle of synchronised pin events passed from the pin conditioner to the port core.
// Assumes a single clk domain on both sides.
`timescale 1ns/1ps
interface rtcsp_pins_if;
   logic selHigh;
   logic sckRise;
   logic sckFall;
   logic dataIn;
   modport src (output selHigh, output sckRise, output sckFall, output dataIn);
   modport dst (input selHigh, input sckRise, input sckFall, input dataIn);
endinterface

//--- core/rtcsp_pin_sync.sv
// Pin conditioner: two-flop synchronisers on select, serial clock and data,
// plus edge detection on the synchronised serial clock.
// Assumes pins are asynchronous to clk and change far slower than 25 ns.
`timescale 1ns/1ps
module rtcsp_pin_sync (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // Raw pins
   input wire logic selPin,
   input wire logic sckPin,
   input wire logic dataPin,
   // Conditioned events
   rtcsp_pins_if.src ev
);
   logic [2:0] meta_r;
   logic [2:0] sync_r;
   logic sckLast_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // Idle pin levels (select low, clock and data high) avoid a false edge after reset
         meta_r <= 3'h3;
         sync_r <= 3'h3;
         sckLast_r <= 1'b1;
      end else if (clkEn) begin
         meta_r <= {selPin, sckPin, dataPin};
         sync_r <= meta_r;
         sckLast_r <= sync_r[1];
      end
   end

   assign ev.selHigh = sync_r[2];
   assign ev.dataIn = sync_r[0];
   assign ev.sckRise = clkEn & sync_r[1] & ~sckLast_r;
   assign ev.sckFall = clkEn & ~sync_r[1] & sckLast_r;
endmodule

//--- core/rtc_serial_port.sv
// Three-wire command port of a real-time clock: header capture, command decode,
// serial read and write of status and time registers, serial write of the alarm register.
// Assumes a slow serial clock from the host and an external pull-up on the data line.
//
// Overview of operation
// - Header is preamble, three command bits, then one direction bit.
// - Undefined command codes cause no operation at all.
// - 001 status, 010 time from year, 011 time from hour.
// - 100 selects the write-only alarm or frequency-duty register.
// - 000 resets calendar and time; direction bit is ignored.
// - Header latched on the eighth rising serial-clock edge.
// - Direction 1: shift register data out on later falling edges.
// - Direction 0: store incoming bits on later falling edges.
// - Fewer than eight clocks: keep waiting, process nothing.
// - Clocks beyond the command's bit count are ignored.
// - Time is 56 BCD bits, LSB first from the year low digit.
// - Status is eight bits; power-fail flag cannot be written.
// - Alarm register is sixteen bits and write-only.
`timescale 1ns/1ps
`include "rtcsp_defs.svh"
module rtc_serial_port (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // Serial pins
   input wire logic selPin,
   input wire logic sckPin,
   input wire logic serial_data_pin_level,
   output logic serial_data_pin_value,
   output logic serial_data_pin_oe,
   // Power-fail input from the clock core, register contents towards it
   input wire logic powerFail,
   output logic [55:0] timeData,
   output logic [7:0] statusData,
   output logic [15:0] alarmData,
   output logic timeWritten,
   output logic testMode
);
   rtcsp_pins_if pins ();

   rtcsp_pin_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .selPin(selPin),
      .sckPin(sckPin),
      .dataPin(serial_data_pin_level),
      .ev(pins)
   );

   function automatic logic [6:0] bitsFor(input rtcsp_pkg::rtcsp_sel_t s);
      case (s)
         rtcsp_pkg::SEL_STATUS: bitsFor = `RTCSP_STATUS_BITS;
         rtcsp_pkg::SEL_TIME: bitsFor = `RTCSP_TIME_BITS;
         rtcsp_pkg::SEL_HOUR: bitsFor = `RTCSP_HOUR_BITS;
         rtcsp_pkg::SEL_ALARM: bitsFor = `RTCSP_ALARM_BITS;
         default: bitsFor = 7'h00;
      endcase
   endfunction

   rtcsp_pkg::rtcsp_phase_t phase_r, phase_nxt;
   rtcsp_pkg::rtcsp_sel_t sel_r, sel_nxt;
   logic [3:0] hdrCnt_r;
   logic [6:0] header_r;
   logic [6:0] bitCnt_r;
   logic [55:0] time_r;
   logic [7:0] status_r;
   logic [15:0] alarm_r;
   logic dOut_r;
   logic dOe_r;
   logic test_r;
   logic timeWr_r;

   // Header decode on the eighth rising edge
   wire [7:0] fullHdr = {header_r, pins.dataIn};
   wire [3:0] hdrPre = fullHdr[7:4];
   wire [2:0] hdrCmd = fullHdr[3:1];
   wire hdrRead = fullHdr[0];
   wire hdrDone = (phase_r == rtcsp_pkg::PH_HEADER) && pins.sckRise &&
      (hdrCnt_r == `RTCSP_HDR_BITS - 4'h1);
   wire preOk = (hdrPre == `RTCSP_PREAMBLE);
   wire [6:0] need = bitsFor(sel_r);
   wire [6:0] pos = (sel_r == rtcsp_pkg::SEL_HOUR) ? bitCnt_r + `RTCSP_HOUR_OFFSET : bitCnt_r;
   wire inRange = bitCnt_r < need;
   wire readFall = (phase_r == rtcsp_pkg::PH_READ) && pins.sckFall && inRange;
   wire writeFall = (phase_r == rtcsp_pkg::PH_WRITE) && pins.sckFall && inRange;
   wire selBit = (sel_r == rtcsp_pkg::SEL_STATUS) ? status_r[bitCnt_r[2:0]] :
      (sel_r == rtcsp_pkg::SEL_ALARM) ? 1'b1 : time_r[pos[5:0]];

   always_comb begin
      phase_nxt = phase_r;
      sel_nxt = sel_r;
      if (hdrDone) begin
         phase_nxt = rtcsp_pkg::PH_DONE;
         sel_nxt = rtcsp_pkg::SEL_NONE;
         if (preOk) begin
            case (hdrCmd)
               `RTCSP_CMD_STATUS: sel_nxt = rtcsp_pkg::SEL_STATUS;
               `RTCSP_CMD_TIME_YEAR: sel_nxt = rtcsp_pkg::SEL_TIME;
               `RTCSP_CMD_TIME_HOUR: sel_nxt = rtcsp_pkg::SEL_HOUR;
               `RTCSP_CMD_ALARM: sel_nxt = rtcsp_pkg::SEL_ALARM;
               default: sel_nxt = rtcsp_pkg::SEL_NONE;
            endcase
            if (sel_nxt != rtcsp_pkg::SEL_NONE) begin
               phase_nxt = hdrRead ? rtcsp_pkg::PH_READ : rtcsp_pkg::PH_WRITE;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || (clkEn && !pins.selHigh)) begin
         phase_r <= rtcsp_pkg::PH_HEADER;
         sel_r <= rtcsp_pkg::SEL_NONE;
         hdrCnt_r <= 4'h0;
         header_r <= 7'h00;
         bitCnt_r <= 7'h00;
         dOut_r <= 1'b1;
         dOe_r <= 1'b0;
      end else if (clkEn) begin
         phase_r <= phase_nxt;
         sel_r <= sel_nxt;
         if (pins.sckRise && phase_r == rtcsp_pkg::PH_HEADER) begin
            hdrCnt_r <= hdrCnt_r + 4'h1;
            header_r <= fullHdr[6:0];
         end
         if (readFall || writeFall) begin
            bitCnt_r <= bitCnt_r + 7'h01;
         end
         // Open drain: only a zero is driven, a one floats to the pull-up
         if (readFall) begin
            dOut_r <= 1'b0;
            dOe_r <= ~selBit;
         end else if (phase_r == rtcsp_pkg::PH_READ && pins.sckFall) begin
            dOe_r <= 1'b0;
         end
      end
   end

   // Register storage survives select changes; only reset, commands and powerFail touch it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         time_r <= `RTCSP_TIME_RESET;
         status_r <= `RTCSP_STATUS_RESET;
         alarm_r <= `RTCSP_ALARM_RESET;
         test_r <= 1'b0;
         timeWr_r <= 1'b0;
      end else if (clkEn) begin
         timeWr_r <= 1'b0;
         if (powerFail) begin
            status_r[`RTCSP_POWER_BIT] <= 1'b1;
         end
         if (hdrDone && preOk) begin
            if (hdrCmd == `RTCSP_CMD_RESET) begin
               time_r <= `RTCSP_TIME_RESET;
               status_r[`RTCSP_POWER_BIT] <= powerFail;
               test_r <= 1'b0;
            end else if (hdrCmd == `RTCSP_CMD_TEST_ON) begin
               test_r <= 1'b1;
            end else if (hdrCmd == `RTCSP_CMD_TEST_OFF) begin
               test_r <= 1'b0;
            end
         end
         if (writeFall && pins.selHigh) begin
            if (sel_r == rtcsp_pkg::SEL_STATUS) begin
               if (bitCnt_r[2:0] != `RTCSP_POWER_BIT) begin
                  status_r[bitCnt_r[2:0]] <= pins.dataIn;
               end
            end else if (sel_r == rtcsp_pkg::SEL_ALARM) begin
               alarm_r[bitCnt_r[3:0]] <= pins.dataIn;
            end else begin
               time_r[pos[5:0]] <= pins.dataIn;
               timeWr_r <= (bitCnt_r == need - 7'h01);
            end
         end
      end
   end

   assign serial_data_pin_value = dOut_r;
   assign serial_data_pin_oe = dOe_r;
   assign timeData = time_r;
   assign statusData = status_r;
   assign alarmData = alarm_r;
   assign timeWritten = timeWr_r;
   assign testMode = test_r;
endmodule

//--- tb/rtcsp_props.sv
// Checker for the three-wire command port registers and data-line enable.
// Assumes powerFail stays low while clkEn is low; bound onto the port's top module.
`timescale 1ns/1ps
module rtcsp_props (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pins and registers
   input wire logic selPin,
   input wire logic powerFail,
   input wire logic serial_data_pin_oe,
   input wire logic [55:0] timeData,
   input wire logic [15:0] alarmData,
   input wire logic [7:0] statusData,
   input wire logic timeWritten
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Six idle cycles cover the two-flop sync plus the registered enable
   sequence selIdle;
      !selPin[*6];
   endsequence
   oe_release_a:
      assert property (selIdle |-> !serial_data_pin_oe) else $error("data line held while idle");
   reset_values_a:
      assert property ($fell(sys_rst) |-> timeData == 56'h00000000010100 && alarmData == 16'h8000)
         else $error("register reset value wrong");
   idle_stable_a:
      assert property (selIdle |=> $stable(timeData) && $stable(alarmData))
         else $error("register changed while idle");
   power_set_a:
      assert property (powerFail |=> statusData[7]) else $error("power flag not set");
   power_wins_a:
      assert property ($fell(statusData[7]) |-> !$past(powerFail)) else $error("power flag lost");
   read_no_write_a:
      assert property (serial_data_pin_oe |-> $stable(alarmData)) else $error("alarm moved in read");
   oe_in_frame_a:
      assert property (serial_data_pin_oe |-> $past(selPin, 6)) else $error("drive outside frame");
   written_pulse_a:
      assert property (timeWritten |=> !timeWritten) else $error("written pulse too long");
endmodule
bind rtc_serial_port rtcsp_props chk (.clk(clk), .sys_rst(sys_rst), .selPin(selPin),
   .powerFail(powerFail), .serial_data_pin_oe(serial_data_pin_oe), .timeData(timeData),
   .alarmData(alarmData), .statusData(statusData), .timeWritten(timeWritten));

//--- tb/rtcsp_host_model.sv
// Host side of the three-wire port: select, serial clock and data drive.
// Assumes the bench resolves the open-drain line and returns it on lineIn.
`timescale 1ns/1ps
module rtcsp_host_model (
   // Clock
   input wire logic clk,
   // Pins
   output logic selPin,
   output logic sckPin,
   output logic dataOut,
   input wire logic lineIn
);
   initial begin
      selPin = 1'b0;
      sckPin = 1'b1;
      dataOut = 1'b1;
   end
   // Callers pass normal command codes and the undefined code 101, never the test pair
   task automatic frame(input logic [7:0] hdr, input int cnt, input logic [55:0] wd,
      output logic [55:0] rd);
      rd = '0;
      @(posedge clk) selPin <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < cnt; i++) begin
         @(posedge clk) sckPin <= 1'b0;
         dataOut <= (i < 8) ? hdr[7 - i] : ((i < 64) ? wd[i - 8] : 1'b1);
         repeat (4) @(posedge clk);
         sckPin <= 1'b1;
         repeat (4) @(posedge clk);
         if (i >= 8 && i < 64) rd[i - 8] = lineIn;
      end
      // Released line floats to the pull-up level
      @(posedge clk) selPin <= 1'b0;
      dataOut <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the three-wire command port.
// Assumes the checker and host model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic powerFail = 1'b0;
   logic clkEn = 1'b1;
   logic selPin, sckPin, dataOut, oe, dOut, tw, tm;
   logic [55:0] timeData, rd;
   logic [7:0] statusData;
   logic [15:0] alarmData;
   int mismatches = 0;
   int check_count = 0;
   int twCount = 0;
   // Open-drain line: either side may pull it low, otherwise the pull-up wins
   wire logic sioLine = (oe ? dOut : 1'b1) & dataOut;
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (tw === 1'b1) begin
         twCount <= twCount + 1;
      end
   end
   rtcsp_host_model host (.clk(clk), .selPin(selPin), .sckPin(sckPin), .dataOut(dataOut),
      .lineIn(sioLine));
   rtc_serial_port dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .selPin(selPin),
      .sckPin(sckPin), .serial_data_pin_level(sioLine), .serial_data_pin_value(dOut),
      .serial_data_pin_oe(oe), .powerFail(powerFail), .timeData(timeData),
      .statusData(statusData), .alarmData(alarmData), .timeWritten(tw), .testMode(tm));
   task automatic t_status();
      `CHK("status init", 8'h82, statusData)
      host.frame(8'h62, 16, 56'h35, rd);
      `CHK("status wr", 8'hb5, statusData)
      host.frame(8'h63, 16, '1, rd);
      `CHK("status rd", 8'hb5, rd[7:0])
      `CHK("line released", 1'b0, oe)
      `CHK("pin idle level", 1'b1, dOut)
   endtask
   task automatic t_time();
      // Six spare clocks past the 56 data bits must change nothing
      host.frame(8'h64, 70, 56'h45301203150824, rd);
      `CHK("time wr", 56'h45301203150824, timeData)
      `CHK("written pulses", 1, twCount)
      host.frame(8'h65, 64, '1, rd);
      `CHK("time rd", 56'h45301203150824, rd)
      host.frame(8'h67, 32, '1, rd);
      `CHK("hour rd", 24'h453012, rd[23:0])
   endtask
   task automatic t_alarm();
      `CHK("alarm init", 16'h8000, alarmData)
      host.frame(8'h68, 24, 56'h1234, rd);
      `CHK("alarm wr", 16'h1234, alarmData)
      host.frame(8'h69, 24, '1, rd);
      `CHK("alarm rd", 16'hffff, rd[15:0])
   endtask
   task automatic t_refuse();
      host.frame(8'h62, 5, 56'h0, rd);
      `CHK("short hdr", 8'hb5, statusData)
      host.frame(8'h6a, 24, 56'h0, rd);
      `CHK("bad code st", 8'hb5, statusData)
      `CHK("bad code al", 16'h1234, alarmData)
      // Wrong preamble 0101 ahead of a status write
      host.frame(8'h52, 16, 56'h0, rd);
      `CHK("bad preamble", 8'hb5, statusData)
   endtask
   task automatic t_reset_cmd();
      host.frame(8'h61, 8, '1, rd);
      `CHK("reset time", 56'h00000000010100, timeData)
      `CHK("reset status", 8'h35, statusData)
      @(posedge clk) powerFail <= 1'b1;
      @(posedge clk) powerFail <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("power flag", 8'hb5, statusData)
      `CHK("test mode", 1'b0, tm)
   endtask
   task automatic t_freeze();
      // A status write sent while the enable is low must leave no trace
      clkEn <= 1'b0;
      host.frame(8'h62, 16, 56'h0, rd);
      `CHK("frozen status", 8'hb5, statusData)
      @(posedge clk) clkEn <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_status();
      t_time();
      t_alarm();
      t_refuse();
      t_reset_cmd();
      t_freeze();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule
